// [uch_map.vh]
`ifndef UCH_MAP_VH
`define UCH_MAP_VH

// Channel register offsets on the 4-bit address.
`define UCH_OFF_HOLD        4'h0
`define UCH_OFF_IER         4'h1
`define UCH_OFF_ISR         4'h2
`define UCH_OFF_LCR         4'h3
`define UCH_OFF_LSR         4'h5
`define UCH_OFF_DLL         4'h0
`define UCH_OFF_DLM         4'h1
`define UCH_OFF_EFR         4'h2

// Line control fields and the key that opens the enhanced feature register.
`define UCH_LCR_DLAB        7
`define UCH_LCR_EFR_KEY     8'hbf

// Enhanced feature field that unlocks the upper enable bits.
`define UCH_EFR_ENH         4

// Interrupt enable fields.
`define UCH_IER_RXRDY       0
`define UCH_IER_TXRDY       1
`define UCH_IER_RXLINE      2
`define UCH_IER_MODEM       3
`define UCH_IER_RSVD        4
`define UCH_IER_SWFLOW      5
`define UCH_IER_RTS         6
`define UCH_IER_CTS         7
`define UCH_IER_LOW_MASK    8'h0f
`define UCH_IER_HIGH_MASK   8'he0

// Fifo control fields.
`define UCH_FCR_ENABLE      0
`define UCH_FCR_RX_RESET    1
`define UCH_FCR_TX_RESET    2

// Identification codes in bits 5 to 0, by priority.
`define UCH_ID_RXLINE       6'h06
`define UCH_ID_RXRDY        6'h04
`define UCH_ID_RXTMO        6'h0c
`define UCH_ID_TXRDY        6'h02
`define UCH_ID_MODEM        6'h00
`define UCH_ID_SWFLOW       6'h10
`define UCH_ID_CTSRTS       6'h20
`define UCH_ID_NONE         6'h01

// Reset values.
`define UCH_RST_IER         8'h00
`define UCH_RST_ISR         8'h01
`define UCH_RST_LCR         8'h00
`define UCH_RST_EFR         8'h00
`define UCH_RST_DIV         16'h0000

`endif

// [uch_sync.v]
`timescale 1ns/10ps
module uch_sync #(
  parameter           WIDTH     = 1,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  // Clock and reset.
  input  wire             ref_clk_in,
  input  wire             rst_n_in,
  // Asynchronous input and its synchronised copy.
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_q;

  // Two flops; the first one feeds only the second to keep metastability contained.
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q   <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// [uch_irq_prio.v]
`timescale 1ns/10ps
`include "uch_map.vh"
module uch_irq_prio (
  // Enabled pending sources, index 0 is the highest priority.
  input  wire [6:0] pend_in,
  // Encoded identification and the one-hot winner.
  output reg  [5:0] ident_out,
  output reg  [6:0] sel_out
);

  // Fixed priority; a lower source simply waits, its latch is untouched here.
  always @* begin
    ident_out = `UCH_ID_NONE;
    sel_out   = 7'h00;
    if (pend_in[0]) begin
      ident_out = `UCH_ID_RXLINE;
      sel_out   = 7'h01;
    end else if (pend_in[1]) begin
      ident_out = `UCH_ID_RXRDY;
      sel_out   = 7'h02;
    end else if (pend_in[2]) begin
      ident_out = `UCH_ID_RXTMO;
      sel_out   = 7'h04;
    end else if (pend_in[3]) begin
      ident_out = `UCH_ID_TXRDY;
      sel_out   = 7'h08;
    end else if (pend_in[4]) begin
      ident_out = `UCH_ID_MODEM;
      sel_out   = 7'h10;
    end else if (pend_in[5]) begin
      ident_out = `UCH_ID_SWFLOW;
      sel_out   = 7'h20;
    end else if (pend_in[6]) begin
      ident_out = `UCH_ID_CTSRTS;
      sel_out   = 7'h40;
    end
  end

endmodule

// [uch_channel_regs.v]
// Behaviour
// - Receive port read returns and pops oldest byte.
// - Transmit port write appends byte to fifo.
// - Transmit write dropped while fifo full.
// - Line state shows fifo full and empty.
// - These registers reachable only with divisor select clear.
// - Divisor select redirects low offsets to divisor.
// - Enable bits gate seven sources, bit four zero.
// - Transmit ready on slot empty or space above trigger.
// - Upper enable bits writable only with enhanced bit.
// - Ident bit zero low when pending, idle 01.
// - Ident bits seven and six mirror fifo enable.
// - Fifo enable selects single slot or fifos.
// - Top three priorities: line error, data, timeout.
// - Then transmit ready, then modem status.
// - Lowest: flow or special char, then cts/rts.
// - Xoff flag clears only on matching xon.
// - Special character flag clears on ident read.
`timescale 1ns/10ps
`include "uch_map.vh"
module uch_channel_regs (
  // Clock and reset.
  input  wire        ref_clk_in,
  input  wire        rst_n_in,
  // Host parallel bus pins.
  input  wire        cs_n_in,
  input  wire        rd_n_in,
  input  wire        wr_n_in,
  input  wire [3:0]  addr_in,
  input  wire [7:0]  data_in,
  output reg  [7:0]  data_out,
  output reg         data_oe_out,
  // Receive fifo side.
  input  wire [7:0]  rx_data_in,
  input  wire        rx_empty_in,
  input  wire        rx_full_in,
  input  wire        rx_trig_hit_in,
  input  wire        rx_timeout_in,
  output reg         rx_pop_out,
  // Transmit fifo side.
  input  wire        tx_empty_in,
  input  wire        tx_full_in,
  input  wire        tx_space_above_trig_in,
  output reg         tx_push_out,
  output reg  [7:0]  tx_data_out,
  // Line, modem and flow events.
  input  wire [3:0]  line_err_set_in,
  input  wire        modem_change_in,
  input  wire        xoff_det_in,
  input  wire        xon_det_in,
  input  wire        special_det_in,
  input  wire        cts_inactive_in,
  input  wire        rts_inactive_in,
  // Configuration towards the channel core.
  output reg  [7:0]  lcr_out,
  output reg  [7:0]  efr_out,
  output reg  [15:0] divisor_out,
  output reg         fifo_enable_out,
  output reg  [1:0]  rx_trig_sel_out,
  output reg  [1:0]  tx_trig_sel_out,
  output reg         rx_fifo_reset_out,
  output reg         tx_fifo_reset_out,
  output reg         irq_pending_out
);

  // Synchronised host pins.
  wire       cs_n_s;
  wire       rd_n_s;
  wire       wr_n_s;
  wire [3:0] addr_s;
  wire [7:0] data_s;

  // Access tracking.
  reg        rd_act_q;
  reg        wr_act_q;
  reg [3:0]  rd_addr_q;
  reg [3:0]  wr_addr_q;
  reg [7:0]  wr_data_q;
  reg [6:0]  rd_sel_q;
  reg        rd_isr_q;
  reg        rd_rhr_q;
  reg        rd_lsr_q;

  // Registers and interrupt latches.
  reg [7:0]  ier_q;
  reg [3:0]  err_q;
  reg        txrdy_q;
  reg        xoff_q;
  reg        special_q;
  reg        cts_q;
  reg        rts_q;
  reg        tx_empty_q;
  reg        tx_space_q;

  wire       rd_live;
  wire       wr_live;
  wire       rd_start;
  wire       rd_end;
  wire       wr_end;
  wire       normal_bank;
  wire       efr_bank;
  wire [6:0] pend;
  wire [5:0] ident;
  wire [6:0] sel;
  wire [7:0] lsr_val;
  wire       txrdy_cond;
  wire       txrdy_rise;
  wire       wr_thr;
  wire       wr_ier;
  reg  [7:0] rd_val;

  // Returns true when an access at the given offset targets the given register bank.
  function hit;
    input [3:0] a;
    input [3:0] off;
    input       bank;
    begin
      hit = bank && (a == off);
    end
  endfunction

  // Host strobes are asynchronous, so all pins pass two flops first.
  uch_sync #(
    .WIDTH     (3),
    .RESET_VAL (3'h7)
  ) u_sync_ctl (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .async_in   ({cs_n_in, rd_n_in, wr_n_in}),
    .sync_out   ({cs_n_s, rd_n_s, wr_n_s})
  );

  uch_sync #(
    .WIDTH     (12),
    .RESET_VAL (12'h000)
  ) u_sync_bus (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .async_in   ({addr_in, data_in}),
    .sync_out   ({addr_s, data_s})
  );

  // Strobe phases; side effects happen once per access, at its end.
  assign rd_live  = !cs_n_s && !rd_n_s;
  assign wr_live  = !cs_n_s && !wr_n_s;
  assign rd_start = rd_live && !rd_act_q;
  assign rd_end   = !rd_live && rd_act_q;
  assign wr_end   = !wr_live && wr_act_q;

  // Bank select by the divisor access bit.
  assign normal_bank = !lcr_out[`UCH_LCR_DLAB];
  assign efr_bank    = (lcr_out == `UCH_LCR_EFR_KEY);

  // Line state: data ready, sticky errors, transmit space, transmit empty, receive full.
  assign lsr_val = {rx_full_in, tx_empty_in, !tx_full_in, err_q, !rx_empty_in};

  // Enabled sources in priority order; disabled sources keep their latches.
  assign pend[0] = ier_q[`UCH_IER_RXLINE] && (err_q != 4'h0);
  assign pend[1] = ier_q[`UCH_IER_RXRDY] && (fifo_enable_out ? rx_trig_hit_in : !rx_empty_in);
  assign pend[2] = ier_q[`UCH_IER_RXRDY] && fifo_enable_out && rx_timeout_in;
  assign pend[3] = ier_q[`UCH_IER_TXRDY] && txrdy_q;
  assign pend[4] = ier_q[`UCH_IER_MODEM] && modem_change_in;
  assign pend[5] = ier_q[`UCH_IER_SWFLOW] && (xoff_q || special_q);
  assign pend[6] = (ier_q[`UCH_IER_CTS] && cts_q) || (ier_q[`UCH_IER_RTS] && rts_q);

  uch_irq_prio u_prio (
    .pend_in   (pend),
    .ident_out (ident),
    .sel_out   (sel)
  );

  // Transmit ready condition depends on the holding mode.
  assign txrdy_cond = fifo_enable_out ? tx_space_above_trig_in : tx_empty_in;
  assign txrdy_rise = fifo_enable_out ? (tx_space_above_trig_in && !tx_space_q)
                                      : (tx_empty_in && !tx_empty_q);

  assign wr_thr = wr_end && hit(wr_addr_q, `UCH_OFF_HOLD, normal_bank);
  assign wr_ier = wr_end && hit(wr_addr_q, `UCH_OFF_IER, normal_bank);

  // Read multiplexer; unmapped offsets read as zero.
  always @* begin
    rd_val = 8'h00;
    if (normal_bank) begin
      case (addr_s)
        `UCH_OFF_HOLD: begin
          rd_val = rx_data_in;
        end
        `UCH_OFF_IER: begin
          rd_val = ier_q & ~(8'h01 << `UCH_IER_RSVD);
        end
        `UCH_OFF_ISR: begin
          rd_val = {fifo_enable_out, fifo_enable_out, ident};
        end
        `UCH_OFF_LCR: begin
          rd_val = lcr_out;
        end
        `UCH_OFF_LSR: begin
          rd_val = lsr_val;
        end
        default: begin
          rd_val = 8'h00;
        end
      endcase
    end else begin
      case (addr_s)
        `UCH_OFF_DLL: begin
          rd_val = divisor_out[7:0];
        end
        `UCH_OFF_DLM: begin
          rd_val = divisor_out[15:8];
        end
        `UCH_OFF_EFR: begin
          rd_val = efr_bank ? efr_out : 8'h00;
        end
        `UCH_OFF_LCR: begin
          rd_val = lcr_out;
        end
        default: begin
          rd_val = 8'h00;
        end
      endcase
    end
  end

  // Bus tracking: read data is captured at strobe start so it stays still on the pins.
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_act_q    <= 1'b0;
      wr_act_q    <= 1'b0;
      rd_addr_q   <= 4'h0;
      wr_addr_q   <= 4'h0;
      wr_data_q   <= 8'h00;
      rd_sel_q    <= 7'h00;
      rd_isr_q    <= 1'b0;
      rd_rhr_q    <= 1'b0;
      rd_lsr_q    <= 1'b0;
      data_out    <= 8'h00;
      data_oe_out <= 1'b0;
    end else begin
      rd_act_q    <= rd_live;
      wr_act_q    <= wr_live;
      data_oe_out <= rd_live;
      if (wr_live) begin
        wr_addr_q <= addr_s;
        wr_data_q <= data_s;
      end
      if (rd_start) begin
        rd_addr_q <= addr_s;
        data_out  <= rd_val;
        rd_sel_q  <= sel;
        rd_isr_q  <= hit(addr_s, `UCH_OFF_ISR, normal_bank);
        rd_rhr_q  <= hit(addr_s, `UCH_OFF_HOLD, normal_bank);
        rd_lsr_q  <= hit(addr_s, `UCH_OFF_LSR, normal_bank);
      end
    end
  end

  // Fifo strobes; a read of an empty fifo pops nothing and a write to a full fifo pushes nothing.
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_pop_out  <= 1'b0;
      tx_push_out <= 1'b0;
      tx_data_out <= 8'h00;
    end else begin
      rx_pop_out  <= rd_end && rd_rhr_q && !rx_empty_in;
      tx_push_out <= wr_thr && !tx_full_in;
      if (wr_thr) begin
        tx_data_out <= wr_data_q;
      end
    end
  end

  // Configuration registers written at the end of a write strobe.
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ier_q             <= `UCH_RST_IER;
      lcr_out           <= `UCH_RST_LCR;
      efr_out           <= `UCH_RST_EFR;
      divisor_out       <= `UCH_RST_DIV;
      fifo_enable_out   <= 1'b0;
      rx_trig_sel_out   <= 2'h0;
      tx_trig_sel_out   <= 2'h0;
      rx_fifo_reset_out <= 1'b0;
      tx_fifo_reset_out <= 1'b0;
    end else begin
      rx_fifo_reset_out <= 1'b0;
      tx_fifo_reset_out <= 1'b0;
      if (wr_ier) begin
        // The upper three bits are locked unless enhanced features are on.
        ier_q <= (wr_data_q & `UCH_IER_LOW_MASK) |
                 ((efr_out[`UCH_EFR_ENH] ? wr_data_q : ier_q) & `UCH_IER_HIGH_MASK);
      end
      if (wr_end && hit(wr_addr_q, `UCH_OFF_ISR, normal_bank)) begin
        fifo_enable_out   <= wr_data_q[`UCH_FCR_ENABLE];
        rx_fifo_reset_out <= wr_data_q[`UCH_FCR_RX_RESET];
        tx_fifo_reset_out <= wr_data_q[`UCH_FCR_TX_RESET];
        // Trigger bits only program while the fifos are being enabled.
        if (wr_data_q[`UCH_FCR_ENABLE]) begin
          rx_trig_sel_out <= wr_data_q[7:6];
          if (efr_out[`UCH_EFR_ENH]) begin
            tx_trig_sel_out <= wr_data_q[5:4];
          end
        end
      end
      if (wr_end && (wr_addr_q == `UCH_OFF_LCR)) begin
        lcr_out <= wr_data_q;
      end
      if (wr_end && hit(wr_addr_q, `UCH_OFF_DLL, !normal_bank)) begin
        divisor_out[7:0] <= wr_data_q;
      end
      if (wr_end && hit(wr_addr_q, `UCH_OFF_DLM, !normal_bank)) begin
        divisor_out[15:8] <= wr_data_q;
      end
      if (wr_end && hit(wr_addr_q, `UCH_OFF_EFR, !normal_bank && efr_bank)) begin
        efr_out <= wr_data_q;
      end
    end
  end

  // Sticky interrupt latches; in every one an arriving event beats a clear in the same cycle.
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      err_q      <= 4'h0;
      txrdy_q    <= 1'b0;
      xoff_q     <= 1'b0;
      special_q  <= 1'b0;
      cts_q      <= 1'b0;
      rts_q      <= 1'b0;
      // Matches the idle level of an empty holding slot, so reset makes no false edge.
      tx_empty_q <= 1'b1;
      tx_space_q <= 1'b0;
    end else begin
      tx_empty_q <= tx_empty_in;
      tx_space_q <= tx_space_above_trig_in;
      // Line errors clear on a line state read.
      err_q <= line_err_set_in | ((rd_end && rd_lsr_q) ? 4'h0 : err_q);
      // Transmit ready clears on a holding write or when its identification was read.
      if (txrdy_rise || (wr_ier && wr_data_q[`UCH_IER_TXRDY] && !ier_q[`UCH_IER_TXRDY]
                         && txrdy_cond)) begin
        txrdy_q <= 1'b1;
      end else if (wr_thr || (rd_end && rd_isr_q && rd_sel_q[3])) begin
        txrdy_q <= 1'b0;
      end
      // Xoff stays until the matching xon, whatever the host reads.
      if (xoff_det_in) begin
        xoff_q <= 1'b1;
      end else if (xon_det_in) begin
        xoff_q <= 1'b0;
      end
      if (special_det_in) begin
        special_q <= 1'b1;
      end else if (rd_end && rd_isr_q && rd_sel_q[5]) begin
        special_q <= 1'b0;
      end
      if (cts_inactive_in) begin
        cts_q <= 1'b1;
      end else if (rd_end && rd_isr_q && rd_sel_q[6]) begin
        cts_q <= 1'b0;
      end
      if (rts_inactive_in) begin
        rts_q <= 1'b1;
      end else if (rd_end && rd_isr_q && rd_sel_q[6]) begin
        rts_q <= 1'b0;
      end
    end
  end

  // Channel interrupt request follows identification bit zero, inverted.
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_pending_out <= 1'b0;
    end else begin
      irq_pending_out <= (pend != 7'h00);
    end
  end

endmodule

// [uch_channel_regs_assertions.sv]
`timescale 1ns/10ps
module uch_channel_regs_assertions (
  // Clock and reset.
  input wire        ref_clk_in,
  input wire        rst_n_in,
  // Host bus pins.
  input wire        cs_n_in,
  input wire        rd_n_in,
  input wire        wr_n_in,
  input wire [3:0]  addr_in,
  input wire [7:0]  data_out,
  input wire        data_oe_out,
  // Fifo side.
  input wire        tx_full_in,
  input wire        rx_empty_in,
  input wire        rx_pop_out,
  input wire        tx_push_out,
  // Configuration.
  input wire [7:0]  lcr_out,
  input wire [15:0] divisor_out,
  input wire        fifo_enable_out
);
  // Every check runs on the channel clock and is quiet in reset.
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  // A read of the ident offset as it first reaches the bus.
  sequence id_read;
    $rose(data_oe_out) && $past(addr_in, 3) == 4'h2 && !lcr_out[7];
  endsequence
  chk_oe_needs_read: assert property (data_oe_out |-> !$past(cs_n_in, 3) && !$past(rd_n_in, 3))
    else $error("bus driven without a read strobe");
  chk_oe_stands: assert property ($rose(data_oe_out) |=> data_oe_out [*2])
    else $error("read data dropped too early");
  chk_push_single: assert property (tx_push_out |=> !tx_push_out ##1 !tx_push_out)
    else $error("push longer than one cycle");
  chk_push_room: assert property (tx_push_out |-> !$past(tx_full_in) && !lcr_out[7])
    else $error("push while full or divisor selected");
  chk_pop_data: assert property (rx_pop_out |-> !$past(rx_empty_in) ##1 !rx_pop_out)
    else $error("pop of empty fifo or long pop");
  chk_ident_mirror: assert property (id_read |-> data_out[7:6] == {2{fifo_enable_out}})
    else $error("ident top bits differ from fifo enable");
  chk_ident_code: assert property (id_read |-> data_out[5:0] inside {6'h06, 6'h04, 6'h0c,
    6'h02, 6'h00, 6'h10, 6'h20, 6'h01})
    else $error("ident code outside the priority table");
  chk_div_select: assert property ($changed(divisor_out) |-> lcr_out[7])
    else $error("divisor changed with select clear");
  chk_cfg_write: assert property ($changed(lcr_out) |-> !$past(wr_n_in, 3) ||
    !$past(wr_n_in, 4) || !$past(wr_n_in, 5))
    else $error("line control changed without a write");
  // Main scenarios reached.
  cov_push: cover property (tx_push_out);
  cov_pop: cover property (rx_pop_out);
  cov_div: cover property ($changed(divisor_out));
endmodule

// [uch_host_model.sv]
`timescale 1ns/10ps
module uch_host_model (
  // Clock.
  input  wire       ref_clk_in,
  // Strobes, offset and write data towards the channel.
  output reg        cs_n_out,
  output reg        rd_n_out,
  output reg        wr_n_out,
  output reg  [3:0] addr_out,
  output reg  [7:0] data_out,
  // Read data from the channel.
  input  wire [7:0] data_in
);
  // The bus idles with all strobes high.
  initial begin
    cs_n_out = 1'b1;
    rd_n_out = 1'b1;
    wr_n_out = 1'b1;
    addr_out = 4'hf;
    data_out = 8'hff;
  end
  // One cycle: strobe low five clocks, then high at least six. Offset and
  // data outlive the strobe because the channel samples them late.
  task access(input wr, input [3:0] a, input [7:0] d, output [7:0] q);
    begin
      @(negedge ref_clk_in);
      cs_n_out <= 1'b0;
      rd_n_out <= wr;
      wr_n_out <= !wr;
      addr_out <= a;
      data_out <= d;
      repeat (5) @(negedge ref_clk_in);
      q = data_in;
      cs_n_out <= 1'b1;
      rd_n_out <= 1'b1;
      wr_n_out <= 1'b1;
      repeat (4) @(negedge ref_clk_in);
      // Released lines show the inverse so a stale value cannot pass.
      addr_out <= ~a;
      data_out <= ~d;
      repeat (2) @(negedge ref_clk_in);
    end
  endtask
endmodule

// [uch_channel_regs_tb.sv]
`timescale 1ns/10ps
module uch_channel_regs_tb;
  reg         ref_clk_in, rst_n_in, rx_empty, rx_full, trig, tmo, tx_empty, tx_full, space;
  reg         modem;
  reg  [5:0]  ev;
  reg  [7:0]  rx_data, q;
  reg  [23:0] rows [0:4];
  integer     err_count, checked, pushes, pops, i;
  wire        cs_n, rd_n, wr_n, oe, pop, push, irq, fen;
  wire [3:0]  addr;
  wire [7:0]  wdata, rdata, txd, line_control_register, enhanced_feature_register;
  wire [15:0] divisor;

  // Host bus master.
  uch_host_model host (.ref_clk_in(ref_clk_in), .cs_n_out(cs_n), .rd_n_out(rd_n),
    .wr_n_out(wr_n), .addr_out(addr), .data_out(wdata), .data_in(rdata));
  // Event bits: 0 overrun, 1 special, 2 xoff, 3 xon, 4 cts, 5 rts.
  uch_channel_regs dut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .cs_n_in(cs_n),
    .rd_n_in(rd_n), .wr_n_in(wr_n), .addr_in(addr), .data_in(wdata), .data_out(rdata),
    .data_oe_out(oe), .rx_data_in(rx_data), .rx_empty_in(rx_empty), .rx_full_in(rx_full),
    .rx_trig_hit_in(trig), .rx_timeout_in(tmo), .rx_pop_out(pop), .tx_empty_in(tx_empty),
    .tx_full_in(tx_full), .tx_space_above_trig_in(space), .tx_push_out(push),
    .tx_data_out(txd), .line_err_set_in({3'h0, ev[0]}), .modem_change_in(modem),
    .xoff_det_in(ev[2]), .xon_det_in(ev[3]), .special_det_in(ev[1]),
    .cts_inactive_in(ev[4]), .rts_inactive_in(ev[5]), .lcr_out(line_control_register), .efr_out(enhanced_feature_register),
    .divisor_out(divisor), .fifo_enable_out(fen), .rx_trig_sel_out(), .tx_trig_sel_out(),
    .rx_fifo_reset_out(), .tx_fifo_reset_out(), .irq_pending_out(irq));

  // Free running 40 MHz clock.
  initial begin
    ref_clk_in = 1'b0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end
  // Fifo traffic is counted here rather than sampled by the tests.
  always @(posedge ref_clk_in) begin
    if (push) pushes = pushes + 1;
    if (pop) pops = pops + 1;
  end
  task cmp(input [63:0] n, input [7:0] e, input [7:0] g);
    begin
      checked = checked + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("wrong value %0s expected %h seen %h", n, e, g);
      end
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    begin
      host.access(1'b1, a, d, q);
    end
  endtask
  task rdc(input [3:0] a, input [7:0] e);
    begin
      host.access(1'b0, a, 8'h00, q);
      cmp({"off_", 8'h30 + {4'h0, a}}, e, q);
    end
  endtask
  // Events are one-cycle pulses, as the channel core gives them.
  task pulse(input [5:0] m);
    begin
      @(negedge ref_clk_in);
      ev = m;
      @(negedge ref_clk_in);
      ev = 6'h00;
    end
  endtask
  task done(input [63:0] n);
    begin
      $display("test %0s finished", n);
    end
  endtask
  task stop_test;
    begin
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
        $display("== PASSED ==");
      end else begin
        $display("== FAILED ==");
      end
      $finish;
    end
  endtask
  // A hang ends the run as a mismatch.
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    err_count = err_count + 1;
    stop_test;
  end
  // Main sequence.
  initial begin
    rst_n_in = 1'b0;
    {rx_data, rx_full, trig, tmo, tx_full, space, modem, ev} = 0;
    {rx_empty, tx_empty} = 2'h3;
    err_count = 0;
    checked = 0;
    pushes = 0;
    pops = 0;
    // Row: enable mask, bit0 data present and bit1 modem, expected ident.
    rows[0] = 24'h000301;
    rows[1] = 24'h010104;
    rows[2] = 24'h080200;
    rows[3] = 24'h090304;
    rows[4] = 24'h0c0300;
    repeat (20) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    rst_n_in = 1'b1;
    for (i = 0; i < 5; i = i + 1) begin
      @(negedge ref_clk_in);
      rx_empty = !rows[i][8];
      modem = rows[i][9];
      wr(4'h1, rows[i][23:16]);
      rdc(4'h2, rows[i][7:0]);
      cmp("irq", {7'h00, !rows[i][0]}, {7'h00, irq});
    end
    done("table");
    // Reset in mid-run brings the enables and ident back to idle.
    @(negedge ref_clk_in);
    {rx_empty, modem} = 2'h2;
    rst_n_in = 1'b0;
    repeat (3) @(negedge ref_clk_in);
    rst_n_in = 1'b1;
    rdc(4'h1, 8'h00);
    rdc(4'h2, 8'h01);
    rdc(4'h7, 8'h00);
    done("reset");
    wr(4'h0, 8'ha5);
    cmp("pushes", 8'h01, pushes[7:0]);
    cmp("txdata", 8'ha5, txd);
    @(negedge ref_clk_in);
    {tx_full, tx_empty, rx_empty, rx_data} = {3'h4, 8'h3c};
    wr(4'h0, 8'h5a);
    cmp("pushes", 8'h01, pushes[7:0]);
    rdc(4'h5, 8'h01);
    rdc(4'h0, 8'h3c);
    cmp("pops", 8'h01, pops[7:0]);
    @(negedge ref_clk_in);
    {tx_full, rx_empty} = 2'h1;
    wr(4'h1, 8'h02);
    // An empty fifo returns no usable byte, so only the pop count is checked.
    host.access(1'b0, 4'h0, 8'h00, q);
    cmp("pops", 8'h01, pops[7:0]);
    rdc(4'h2, 8'h01);
    @(negedge ref_clk_in);
    tx_empty = 1'b1;
    rdc(4'h2, 8'h02);
    rdc(4'h2, 8'h01);
    done("holding");
    wr(4'h1, 8'h04);
    pulse(6'h01);
    rdc(4'h2, 8'h06);
    rdc(4'h5, 8'h62);
    rdc(4'h2, 8'h01);
    wr(4'h2, 8'h01);
    cmp("fen", 8'h01, {7'h00, fen});
    wr(4'h1, 8'h01);
    @(negedge ref_clk_in);
    tmo = 1'b1;
    rdc(4'h2, 8'hcc);
    tmo = 1'b0;
    wr(4'h2, 8'h00);
    done("priority");
    wr(4'h1, 8'hff);
    rdc(4'h1, 8'h0f);
    wr(4'h3, 8'hbf);
    wr(4'h2, 8'h10);
    cmp("efr", 8'h10, enhanced_feature_register);
    wr(4'h3, 8'h00);
    wr(4'h1, 8'h20);
    rdc(4'h1, 8'h20);
    pulse(6'h02);
    rdc(4'h2, 8'h10);
    rdc(4'h2, 8'h01);
    pulse(6'h04);
    rdc(4'h2, 8'h10);
    rdc(4'h2, 8'h10);
    pulse(6'h08);
    rdc(4'h2, 8'h01);
    wr(4'h1, 8'h80);
    pulse(6'h10);
    rdc(4'h2, 8'h20);
    rdc(4'h2, 8'h01);
    wr(4'h1, 8'h40);
    pulse(6'h20);
    rdc(4'h2, 8'h20);
    done("flow");
    wr(4'h3, 8'h80);
    wr(4'h0, 8'h34);
    wr(4'h1, 8'h12);
    cmp("div_low", 8'h34, divisor[7:0]);
    cmp("div_high", 8'h12, divisor[15:8]);
    rdc(4'h0, 8'h34);
    cmp("pushes", 8'h01, pushes[7:0]);
    wr(4'h3, 8'h00);
    done("divisor");
    stop_test;
  end
endmodule

bind uch_channel_regs uch_channel_regs_assertions u_chk (.ref_clk_in(ref_clk_in),
  .rst_n_in(rst_n_in), .cs_n_in(cs_n_in), .rd_n_in(rd_n_in), .wr_n_in(wr_n_in),
  .addr_in(addr_in), .data_out(data_out), .data_oe_out(data_oe_out),
  .tx_full_in(tx_full_in), .rx_empty_in(rx_empty_in), .rx_pop_out(rx_pop_out),
  .tx_push_out(tx_push_out), .lcr_out(lcr_out), .divisor_out(divisor_out),
  .fifo_enable_out(fifo_enable_out));
